// ### hw/mso_pkg.sv
// package of the motion sensor output register group
// assumes one 10 MHz clock and a synchronous active-low reset
package mso_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STEP_TOTAL_BYTE0 = 8'h1e;
    localparam logic [7:0] OFS_STEP_TOTAL_BYTE1 = 8'h1f;
    localparam logic [7:0] OFS_STEP_TOTAL_BYTE2 = 8'h20;
    localparam logic [7:0] OFS_STEP_TOTAL_BYTE3 = 8'h21;
    localparam logic [7:0] OFS_DIE_TEMP_READING = 8'h22;
    localparam logic [7:0] OFS_QUEUE_FILL_LOW = 8'h24;
    localparam logic [7:0] OFS_QUEUE_FILL_HIGH = 8'h25;
    localparam logic [7:0] OFS_QUEUE_READ_PORT = 8'h26;
    // queue status flags and step status flag, both cleared by reading them
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h1d;
    localparam logic [7:0] OFS_STEP_FLAGS = 8'h1c;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int FILL_WIDTH = 14;
    localparam int FILL_HIGH_BITS = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int FLAG_STEP_BIT = 2;
    localparam int FLAG_FWM_BIT = 1;
    localparam int FLAG_FFULL_BIT = 0;
    localparam int QUEUE_WIDTH = 8;
    localparam int QUEUE_DEPTH = 16;
    localparam logic [FILL_WIDTH-1:0] FWM_RESET = 14'h0008;
    localparam logic [7:0] TEMP_ZERO_CELSIUS = 8'h17;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mso_req_t;

    typedef struct packed {
        logic step_event;
        logic step_wm_event;
        logic [31:0] step_total;
        logic [7:0] die_temp;
    } mso_sense_t;

    // register read data, upper six fill bits plus reserved bits forced zero
    function automatic logic [7:0] mso_fill_high(input logic [FILL_WIDTH-1:0] fill);
        mso_fill_high = {2'b00, fill[FILL_WIDTH-1:8]};
    endfunction

endpackage

// ### hw/mso_queue.sv
// byte queue, flip-flop storage, valid and ready on both sides
// assumes a single clock and synchronous active-low reset
`timescale 1ns/1ps
module mso_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_ptr_q];
    assign count_o = cnt_q;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// ### hw/mso_flags.sv
// read-to-clear sticky event flags
// assumes events are one-cycle pulses in the core clock domain
`timescale 1ns/1ps
module mso_flags #(
    parameter int N = 3
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [N-1:0] set_i,
    input wire logic clear_i,
    output logic [N-1:0] flags_o
);
    logic [N-1:0] flags_q;
    assign flags_o = flags_q;

    // a set in the clearing cycle survives the clear
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            flags_q <= '0;
        end else if (clear_i) begin
            flags_q <= set_i;
        end else begin
            flags_q <= flags_q | set_i;
        end
    end
endmodule

// ### hw/mso_regs.sv
// output register group of a motion sensor: step total, temperature,
// queue fill level, queue read port and read-to-clear event flags
// assumes a serial host front end delivers one-cycle rd/wr strobes
`timescale 1ns/1ps

module mso_regs
    import mso_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire mso_pkg::mso_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    input wire mso_pkg::mso_sense_t sense_i,
    input wire logic [mso_pkg::FILL_WIDTH-1:0] fwm_level_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [7:0] in_data_i,
    output logic [2:0] event_flags_o
);
    import mso_pkg::*;

    // ------------------------------------------------------------
    // sensed values
    // ------------------------------------------------------------
    logic [31:0] step_total_q;
    logic [7:0] die_temp_q;

    // values are sampled each cycle so a multi-byte read sees no tearing
    // only when the host reads the low byte first (it latches the upper three)
    logic [23:0] step_upper_q;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            step_total_q <= '0;
            die_temp_q <= REG_RESET;
        end else begin
            step_total_q <= sense_i.step_total;
            die_temp_q <= sense_i.die_temp;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            step_upper_q <= '0;
        end else if (req_i.rd && req_i.addr == OFS_STEP_TOTAL_BYTE0) begin
            step_upper_q <= step_total_q[31:8];
        end
    end

    // ------------------------------------------------------------
    // queue
    // ------------------------------------------------------------
    logic q_valid;
    logic q_pop;
    logic [7:0] q_data;
    logic [4:0] q_count;
    logic [FILL_WIDTH-1:0] fill;

    assign fill = {{(FILL_WIDTH-5){1'b0}}, q_count};
    // reading an empty queue pops nothing, so the level cannot wrap
    assign q_pop = req_i.rd && (req_i.addr == OFS_QUEUE_READ_PORT);

    mso_queue #(
        .WIDTH(QUEUE_WIDTH),
        .DEPTH(QUEUE_DEPTH)
    ) u_queue (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(in_valid_i),
        .in_ready_o(in_ready_o),
        .in_data_i(in_data_i),
        .out_valid_o(q_valid),
        .out_ready_i(q_pop),
        .out_data_o(q_data),
        .count_o(q_count)
    );

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    logic [FILL_WIDTH-1:0] fill_prev_q;
    logic [2:0] flag_set;
    logic flag_clr;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            fill_prev_q <= '0;
        end else begin
            fill_prev_q <= fill;
        end
    end

    // the queue flags fire on the rising crossing so a steady level does not refire after a read
    always_comb begin
        flag_set = 3'b000;
        flag_set[FLAG_STEP_BIT] = sense_i.step_event || sense_i.step_wm_event;
        flag_set[FLAG_FWM_BIT] = (fwm_level_i != '0) && (fill >= fwm_level_i)
                                 && (fill_prev_q < fwm_level_i);
        flag_set[FLAG_FFULL_BIT] = (fill == QUEUE_DEPTH[FILL_WIDTH-1:0])
                                   && (fill_prev_q != QUEUE_DEPTH[FILL_WIDTH-1:0]);
    end

    // the step flag and the queue flags live in different registers, so each read clears only its own
    logic step_clr;
    logic [1:0] queue_flags;
    logic [0:0] step_flag;

    assign flag_clr = req_i.rd && (req_i.addr == OFS_EVENT_FLAGS);
    assign step_clr = req_i.rd && (req_i.addr == OFS_STEP_FLAGS);

    mso_flags #(
        .N(2)
    ) u_flags (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .set_i(flag_set[1:0]),
        .clear_i(flag_clr),
        .flags_o(queue_flags)
    );

    mso_flags #(
        .N(1)
    ) u_step_flag (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .set_i(flag_set[2:2]),
        .clear_i(step_clr),
        .flags_o(step_flag)
    );

    assign event_flags_o = {step_flag, queue_flags};

    // ------------------------------------------------------------
    // read mux; writes are ignored everywhere in this group
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (req_i.addr)
            OFS_STEP_TOTAL_BYTE0: rd_mux = step_total_q[7:0];
            OFS_STEP_TOTAL_BYTE1: rd_mux = step_upper_q[7:0];
            OFS_STEP_TOTAL_BYTE2: rd_mux = step_upper_q[15:8];
            OFS_STEP_TOTAL_BYTE3: rd_mux = step_upper_q[23:16];
            OFS_DIE_TEMP_READING: rd_mux = die_temp_q;
            OFS_QUEUE_FILL_LOW: rd_mux = fill[7:0];
            OFS_QUEUE_FILL_HIGH: rd_mux = mso_fill_high(fill);
            OFS_QUEUE_READ_PORT: rd_mux = q_valid ? q_data : REG_RESET;
            OFS_EVENT_FLAGS: rd_mux = {6'b000000, event_flags_o[1:0]};
            OFS_STEP_FLAGS: rd_mux = {6'b000000, event_flags_o[FLAG_STEP_BIT], 1'b0};
            default: rd_mux = REG_RESET;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= REG_RESET;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o <= rd_mux;
            end
        end
    end
endmodule

// ### dv/mso_host_model.sv
// host model: one-cycle register reads and writes
// the bench calls access, one transfer at a time
`timescale 1ns/1ps
module mso_host_model
    import mso_pkg::*;
(
    input wire logic core_clk_i,
    output mso_pkg::mso_req_t req_o
);
    initial req_o = '0;
    // an idle cycle after each strobe keeps every access a clean pulse
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        req_o = '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge core_clk_i);
        #1;
        req_o = '0;
    endtask
endmodule

// ### dv/mso_regs_sva.sv
// checker of the output register group, top ports only
// bound into every mso_regs instance
`timescale 1ns/1ps
module mso_regs_sva
    import mso_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire mso_pkg::mso_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire mso_pkg::mso_sense_t sense_i,
    input wire logic in_ready_o,
    input wire logic [2:0] event_flags_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic ev;
    assign ev = sense_i.step_event | sense_i.step_wm_event;
    chk_read_answer: assert property (req_i.rd |=> rvalid_o) else $error("read unanswered");
    chk_no_stray: assert property (!req_i.rd |=> !rvalid_o && $stable(rdata_o)) else $error("stray data");
    chk_high_resv: assert property (req_i.rd && req_i.addr == OFS_QUEUE_FILL_HIGH |=> rdata_o[7:6] == 2'b00)
        else $error("reserved bits set");
    chk_temp_pass: assert property ($past(rstn_i) && req_i.rd && req_i.addr == OFS_DIE_TEMP_READING
        && $stable(sense_i.die_temp) |=> rdata_o == $past(sense_i.die_temp)) else $error("temperature wrong");
    chk_step_set: assert property (ev |=> event_flags_o[FLAG_STEP_BIT]) else $error("step flag missed");
    chk_step_clear: assert property (req_i.rd && req_i.addr == OFS_STEP_FLAGS && !ev
        |=> !event_flags_o[FLAG_STEP_BIT]) else $error("step flag not cleared");
    chk_flags_read: assert property (req_i.rd && req_i.addr == OFS_EVENT_FLAGS
        |=> rdata_o == {6'h00, $past(event_flags_o[1:0])}) else $error("flags read wrong");
    chk_step_read: assert property (req_i.rd && req_i.addr == OFS_STEP_FLAGS
        |=> rdata_o == {6'h00, $past(event_flags_o[FLAG_STEP_BIT]), 1'b0}) else $error("step flag read wrong");
    chk_full_flag: assert property ($fell(in_ready_o) |-> ##[0:1] event_flags_o[FLAG_FFULL_BIT])
        else $error("full flag missed");
endmodule
bind mso_regs mso_regs_sva chk_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .sense_i(sense_i), .in_ready_o(in_ready_o), .event_flags_o(event_flags_o));

// ### dv/tb.sv
// self-checking bench of the output register group
// reads go through the host model; a monitor checks each answer
`timescale 1ns/1ps
module tb;
    import mso_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    mso_req_t req;
    mso_sense_t sense = '0;
    logic iv = 1'b0;
    logic [7:0] id = 8'h00;
    logic [7:0] rdata;
    logic rvalid, irdy;
    logic [2:0] flags;
    logic [7:0] exp_q[$];
    logic [7:0] dq[$];
    int err_total = 0;
    int checks_done = 0;
    always #50 clk = ~clk;
    mso_host_model host_u (.core_clk_i(clk), .req_o(req));
    mso_regs dut_u (.core_clk_i(clk), .rstn_i(rstn), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .sense_i(sense), .fwm_level_i(14'h0008), .in_valid_i(iv), .in_ready_o(irdy), .in_data_i(id),
        .event_flags_o(flags));
    task automatic fail(input string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic results();
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, a, 8'h00);
    endtask
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            checks_done++;
            if (exp_q.size() == 0) begin
                fail("answer without read");
            end else if (rdata !== exp_q.pop_front()) begin
                fail("read data mismatch");
            end
        end
    end
    initial begin
        logic [31:0] st;
        logic [7:0] tc;
        int n;
        void'($urandom(80770));
        tick(4);
        rstn = 1'b1;
        for (int a = 8'h1c; a <= 8'h26; a++) rd(8'(a), 8'h00);
        st = $urandom;
        sense.step_total = st;
        host_u.access(1'b1, OFS_STEP_TOTAL_BYTE0, 8'h5a);
        rd(OFS_STEP_TOTAL_BYTE0, st[7:0]);
        // the live count moves on; upper bytes must stay coherent
        sense.step_total = ~st;
        rd(OFS_STEP_TOTAL_BYTE1, st[15:8]);
        rd(OFS_STEP_TOTAL_BYTE2, st[23:16]);
        rd(OFS_STEP_TOTAL_BYTE3, st[31:24]);
        tc = 8'(13 - 23);
        sense.die_temp = tc;
        rd(OFS_DIE_TEMP_READING, 8'hf6);
        n = 0;
        for (int i = 0; i < 20 && irdy === 1'b1; i++) begin
            id = 8'($urandom);
            iv = 1'b1;
            dq.push_back(id);
            n++;
            tick(1);
            iv = 1'b0;
            tick(1);
        end
        checks_done++;
        if (n != QUEUE_DEPTH) fail("queue depth wrong");
        rd(OFS_EVENT_FLAGS, 8'h03);
        rd(OFS_EVENT_FLAGS, 8'h00);
        rd(OFS_QUEUE_FILL_LOW, 8'(QUEUE_DEPTH));
        rd(OFS_QUEUE_FILL_HIGH, 8'h00);
        rd(OFS_QUEUE_READ_PORT, dq.pop_front());
        rd(OFS_QUEUE_FILL_LOW, 8'(QUEUE_DEPTH - 1));
        while (dq.size() > 0) rd(OFS_QUEUE_READ_PORT, dq.pop_front());
        rd(OFS_QUEUE_READ_PORT, 8'h00);
        rd(OFS_QUEUE_FILL_LOW, 8'h00);
        for (int k = 0; k < 2; k++) begin
            sense.step_event = (k == 0);
            sense.step_wm_event = (k == 1);
            tick(1);
            sense.step_event = 1'b0;
            sense.step_wm_event = 1'b0;
            rd(OFS_STEP_FLAGS, 8'h02);
            rd(OFS_STEP_FLAGS, 8'h00);
        end
        tick(2);
        rstn = 1'b0;
        tick(4);
        rstn = 1'b1;
        rd(OFS_STEP_TOTAL_BYTE3, 8'h00);
        tick(2);
        checks_done++;
        if (exp_q.size() != 0) fail("reads left unanswered");
        results();
    end
    initial begin
        #100000;
        fail("watchdog expired");
        results();
    end
endmodule
